// ===== rtl/lgc_cfg.svh
// offsets, field positions, reset values and counts for the global control bank
`ifndef LGC_CFG_SVH
`define LGC_CFG_SVH
`define LGC_SEG8_BASE 8'h0F
`define LGC_CH_STRIDE 8'h10
`define LGC_FMT_ADDR 8'h80
`define LGC_LOSS_ADDR 8'h81
`define LGC_SRC_ADDR 8'h82
`define LGC_SLC_ADDR 8'h83
`define LGC_FMT_MASK 8'hFB
`define LGC_LOSS_MASK 8'h07
`define LGC_SRC_MASK 8'hC0
`define LGC_SLC_MASK 8'h0C
`define LGC_SEG_MASK 8'h7F
`define LGC_REG_RESET 8'h00
`define LGC_SEG_SIGN 6
`define LGC_FMT_RAIL 7
`define LGC_FMT_AONES 6
`define LGC_FMT_RXEDGE 5
`define LGC_FMT_TXEDGE 4
`define LGC_FMT_POL 3
`define LGC_FMT_GIE 1
`define LGC_FMT_SRST 0
`define LGC_LOSS_MUTE 2
`define LGC_LOSS_EXT 1
`define LGC_LOSS_ICT 0
`define LGC_SRC_TRANSMITTER_ON 7
`define LGC_SRC_TERM 6
`define LGC_SLC_LO 2
`define LGC_LOS_SHORT 13'h0020
`define LGC_LOS_LONG 13'h1000
`define LGC_SRST_MIN_US 10
`define LGC_CLK_MHZ 250
`define LGC_SRST_MIN_CYC (`LGC_SRST_MIN_US * `LGC_CLK_MHZ)
`endif

// ===== rtl/lgc_pkg.sv
// types shared by the global control bank
package lgc_pkg;
    typedef struct packed {
        logic pos;
        logic neg;
    } lgc_rail_t;
    typedef enum logic [1:0] {LGC_SL_60, LGC_SL_65, LGC_SL_70, LGC_SL_55} lgc_slicer_t;
endpackage

// ===== rtl/lgc_global_regs.sv
// global control registers, eighth pulse segment and per-channel loss/mute/polarity logic
//
// Overview of operation
// - each channel keeps an eighth pulse segment in bits 6:0; bit 7 reads zero
// - bit 6 of a segment value is its sign: one positive, zero negative
// - rail format bit one selects single rail for all channels, zero dual rail
// - auto all-ones bit makes a channel in loss of signal transmit all ones
// - receive edge bit set updates receive data on falling edge, else rising
// - transmit edge bit clear samples transmit data on falling edge, set rising
// - polarity bit clear means active high data, set means active low
// - global interrupt enable gates every channel interrupt onto the output
// - soft reset bit held over 10 us resets the channel circuits, not the register contents or pin synchronisers
// - mute bit forces both receive data outputs to zero during loss; clock runs
// - loss of signal after 32 zeros, or 4096 with extended loss bit set
// - test tristate bit floats every output, same as the hardware test pin
// - transmitter enable from global pin or bit, or per channel bits when set
// - termination from per channel bits when clear, from global pin when set
`timescale 1ns/1ps
`include "lgc_cfg.svh"
`default_nettype none
module lgc_global_regs
    import lgc_pkg::*;
#(
    parameter int NCH = 8 // number of line channels
) (
    input wire logic CLK, // 250 MHz system clock
    input wire logic RESET, // asynchronous reset, active high
    input wire logic [7:0] ADDR, // register address
    input wire logic [7:0] WDATA, // write data
    input wire logic WR, // write strobe, one cycle
    input wire logic RD, // read strobe, one cycle
    output logic [7:0] RDATA, // read data, valid the cycle after RD
    input wire logic HOST_MODE, // high: host mode, low: hardware mode
    input wire logic TRANSMITTER_ON_PIN, // global transmitter on pin, asynchronous
    input wire logic TERM_PIN, // global termination select pin, asynchronous
    input wire logic ICT_PIN_N, // hardware test pin, low floats outputs
    input wire logic GLOBAL_TRANSMITTER_ON, // global transmitter on register bit
    input wire logic [NCH-1:0] CH_TRANSMITTER_ON, // per channel transmitter on bits
    input wire logic [NCH-1:0] CH_TERM, // per channel termination bits
    input wire logic [NCH-1:0] CH_IRQ, // per channel interrupt requests
    input wire logic [NCH-1:0] RX_STB, // receive bit strobe per channel
    input wire lgc_rail_t [NCH-1:0] RX_LINE, // recovered receive marks
    input wire logic [NCH-1:0] TX_STB, // transmit bit strobe per channel
    input wire lgc_rail_t [NCH-1:0] TX_IN, // transmit data from system side
    output lgc_rail_t [NCH-1:0] RX_OUT, // receive data to system side
    output lgc_rail_t [NCH-1:0] TX_LINE, // transmit data to line encoder
    output logic [NCH-1:0] LOSS, // receive loss of signal per channel
    output logic [NCH-1:0] TX_ENABLE, // resolved transmitter enable
    output logic [NCH-1:0] TERM_SEL, // resolved termination select
    output logic [NCH*7-1:0] SEG8, // eighth pulse segment per channel
    output logic SINGLE_RAIL, // single rail mode
    output logic RX_FALL_EDGE, // receive data updated on falling edge
    output logic TX_RISE_EDGE, // transmit data sampled on rising edge
    output logic SOFT_RESET, // internal reset for channel circuits
    output lgc_slicer_t SLICER, // slicer threshold code
    output logic IRQ, // gated interrupt request
    output logic OUT_EN // output enable of all device pins
);
    // ************************************************************
    // register bank
    // ************************************************************
    logic [7:0] fmt_ff, loss_ff, src_ff, slc_ff, rdata_ff;
    logic [7:0] nxt_fmt, nxt_loss, nxt_src, nxt_slc, nxt_rdata;
    logic [6:0] seg_ff [NCH];
    logic [6:0] nxt_seg [NCH];
    logic [NCH-1:0] seg_hit;

    // segment address decode, one compare per channel
    for (genvar c = 0; c < NCH; c++) begin : g_dec
        assign seg_hit[c] = (ADDR == 8'(`LGC_SEG8_BASE + c * `LGC_CH_STRIDE));
    end

    // writes store only defined bits so reserved bits always read zero
    always_comb begin
        nxt_fmt = fmt_ff;
        nxt_loss = loss_ff;
        nxt_src = src_ff;
        nxt_slc = slc_ff;
        nxt_seg = seg_ff;
        nxt_rdata = rdata_ff;
        if (WR) begin
            if (ADDR == `LGC_FMT_ADDR) nxt_fmt = WDATA & `LGC_FMT_MASK;
            if (ADDR == `LGC_LOSS_ADDR) nxt_loss = WDATA & `LGC_LOSS_MASK;
            if (ADDR == `LGC_SRC_ADDR) nxt_src = WDATA & `LGC_SRC_MASK;
            if (ADDR == `LGC_SLC_ADDR) nxt_slc = WDATA & `LGC_SLC_MASK;
            for (int i = 0; i < NCH; i++) begin
                if (seg_hit[i]) nxt_seg[i] = WDATA[6:0];
            end
        end
        if (RD) begin
            nxt_rdata = 8'h00; // unmapped addresses read zero
            if (ADDR == `LGC_FMT_ADDR) nxt_rdata = fmt_ff;
            if (ADDR == `LGC_LOSS_ADDR) nxt_rdata = loss_ff;
            if (ADDR == `LGC_SRC_ADDR) nxt_rdata = src_ff;
            if (ADDR == `LGC_SLC_ADDR) nxt_rdata = slc_ff;
            for (int i = 0; i < NCH; i++) begin
                if (seg_hit[i]) nxt_rdata = {1'b0, seg_ff[i]};
            end
        end
    end

    // hardware reset clears the whole bank; soft reset leaves it alone
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            fmt_ff <= `LGC_REG_RESET;
            loss_ff <= `LGC_REG_RESET;
            src_ff <= `LGC_REG_RESET;
            slc_ff <= `LGC_REG_RESET;
            rdata_ff <= `LGC_REG_RESET;
            for (int i = 0; i < NCH; i++) seg_ff[i] <= 7'h00;
        end else begin
            fmt_ff <= nxt_fmt;
            loss_ff <= nxt_loss;
            src_ff <= nxt_src;
            slc_ff <= nxt_slc;
            rdata_ff <= nxt_rdata;
            seg_ff <= nxt_seg;
        end
    end

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [2:0] s1_ff, s2_ff, s3_ff, pin_ff, nxt_pin;
    // a change counts only when the second and third stages agree
    always_comb begin
        nxt_pin = pin_ff;
        for (int i = 0; i < 3; i++) begin
            if (s2_ff[i] == s3_ff[i]) nxt_pin[i] = s3_ff[i];
        end
    end
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            s1_ff <= 3'h4; // test pin idles high
            s2_ff <= 3'h4;
            s3_ff <= 3'h4;
            pin_ff <= 3'h4;
        end else begin
            s1_ff <= {ICT_PIN_N, TERM_PIN, TRANSMITTER_ON_PIN};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            pin_ff <= nxt_pin;
        end
    end

    // ************************************************************
    // global settings
    // ************************************************************
    assign SINGLE_RAIL = fmt_ff[`LGC_FMT_RAIL];
    assign RX_FALL_EDGE = fmt_ff[`LGC_FMT_RXEDGE];
    assign TX_RISE_EDGE = fmt_ff[`LGC_FMT_TXEDGE];
    // held for as long as software keeps the bit set; the host times the 10 us
    assign SOFT_RESET = fmt_ff[`LGC_FMT_SRST];
    assign SLICER = lgc_slicer_t'(slc_ff[`LGC_SLC_LO +: 2]);
    assign IRQ = fmt_ff[`LGC_FMT_GIE] & (|CH_IRQ);
    assign OUT_EN = ~loss_ff[`LGC_LOSS_ICT] & pin_ff[2];
    assign RDATA = rdata_ff;

    // transmitter and termination source muxes
    for (genvar c = 0; c < NCH; c++) begin : g_src
        assign TX_ENABLE[c] = src_ff[`LGC_SRC_TRANSMITTER_ON] ? CH_TRANSMITTER_ON[c] :
            (HOST_MODE ? GLOBAL_TRANSMITTER_ON : pin_ff[0]);
        assign TERM_SEL[c] = src_ff[`LGC_SRC_TERM] ? pin_ff[1] : CH_TERM[c];
        assign SEG8[c*7 +: 7] = seg_ff[c];
    end

    // ************************************************************
    // per channel loss, mute, all ones and polarity
    // ************************************************************
    logic pol;
    logic [12:0] los_limit;
    assign pol = fmt_ff[`LGC_FMT_POL];
    assign los_limit = loss_ff[`LGC_LOSS_EXT] ? `LGC_LOS_LONG : `LGC_LOS_SHORT;

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic [12:0] zcnt_ff, nxt_zcnt;
        logic los_ff, nxt_los, alt_ff, nxt_alt;
        lgc_rail_t rx_ff, nxt_rx, tx_ff, nxt_tx;
        always_comb begin
            nxt_zcnt = zcnt_ff;
            nxt_los = los_ff;
            nxt_alt = alt_ff;
            nxt_rx = rx_ff;
            nxt_tx = tx_ff;
            if (RX_STB[c]) begin
                if (RX_LINE[c].pos | RX_LINE[c].neg) begin
                    nxt_zcnt = 13'h0000;
                    nxt_los = 1'b0;
                end else if (zcnt_ff < los_limit) begin
                    nxt_zcnt = zcnt_ff + 13'h0001;
                    nxt_los = (nxt_zcnt >= los_limit);
                end else begin
                    nxt_los = 1'b1;
                end
                // mute forces zero regardless of polarity
                if (los_ff & loss_ff[`LGC_LOSS_MUTE]) begin
                    nxt_rx = '0;
                end else begin
                    nxt_rx.pos = RX_LINE[c].pos ^ pol;
                    nxt_rx.neg = RX_LINE[c].neg ^ pol;
                end
            end
            if (TX_STB[c]) begin
                if (los_ff & fmt_ff[`LGC_FMT_AONES]) begin
                    // all ones: every bit a mark, alternating rails in dual rail
                    nxt_alt = ~alt_ff;
                    nxt_tx.pos = SINGLE_RAIL | ~alt_ff;
                    nxt_tx.neg = ~SINGLE_RAIL & alt_ff;
                end else begin
                    nxt_tx.pos = TX_IN[c].pos ^ pol;
                    nxt_tx.neg = TX_IN[c].neg ^ pol;
                end
            end
            if (SOFT_RESET) begin
                nxt_zcnt = 13'h0000;
                nxt_los = 1'b0;
                nxt_alt = 1'b0;
                nxt_rx = '0;
                nxt_tx = '0;
            end
        end
        always_ff @(posedge CLK or posedge RESET) begin
            if (RESET) begin
                zcnt_ff <= 13'h0000;
                los_ff <= 1'b0;
                alt_ff <= 1'b0;
                rx_ff <= '0;
                tx_ff <= '0;
            end else begin
                zcnt_ff <= nxt_zcnt;
                los_ff <= nxt_los;
                alt_ff <= nxt_alt;
                rx_ff <= nxt_rx;
                tx_ff <= nxt_tx;
            end
        end
        assign LOSS[c] = los_ff;
        assign RX_OUT[c] = rx_ff;
        assign TX_LINE[c] = tx_ff;
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    a_seg_readback: assert property ((RD && seg_hit[0])
        |=> RDATA == {1'b0, $past(seg_ff[0])}) else $error("segment read data wrong");
    a_seg_sign_kept: assert property ((WR && seg_hit[3])
        |=> SEG8[27] == $past(WDATA[`LGC_SEG_SIGN])) else $error("segment sign bit not kept");
    a_rail_follows: assert property ((WR && ADDR == `LGC_FMT_ADDR)
        |=> SINGLE_RAIL == $past(WDATA[`LGC_FMT_RAIL])) else $error("rail format not updated");
    a_aones_line: assert property ((TX_STB[0] && LOSS[0] && fmt_ff[`LGC_FMT_AONES]
        && !SOFT_RESET && SINGLE_RAIL) |=> TX_LINE[0].pos) else $error("all ones not sent");
    a_edge_bits: assert property ((WR && ADDR == `LGC_FMT_ADDR)
        |=> RX_FALL_EDGE == $past(WDATA[5]) && TX_RISE_EDGE == $past(WDATA[4]))
        else $error("edge select not updated");
    a_pol_invert: assert property ((RX_STB[0] && !LOSS[0] && !SOFT_RESET)
        |=> RX_OUT[0].pos == ($past(RX_LINE[0].pos) ^ $past(pol)))
        else $error("receive polarity wrong");
    a_irq_gate: assert property (!fmt_ff[`LGC_FMT_GIE] |-> !IRQ)
        else $error("interrupt not suppressed");
    a_srst_clear: assert property ((SOFT_RESET && $past(SOFT_RESET))
        |-> LOSS == '0 && RX_OUT == '0 && TX_LINE == '0) else $error("channels not in reset");
    a_mute_zero: assert property ((RX_STB[0] && LOSS[0] && loss_ff[`LGC_LOSS_MUTE])
        |=> RX_OUT[0] == '0) else $error("receive not muted");
    a_los_short: assert property ((!loss_ff[`LGC_LOSS_EXT] && !SOFT_RESET && RX_STB[0]
        && RX_LINE[0] == '0 && g_ch[0].zcnt_ff == 13'h001F) |=> LOSS[0])
        else $error("loss not declared at 32 zeros");
    a_los_early: assert property ((LOSS[0] && !$past(LOSS[0]))
        |-> g_ch[0].zcnt_ff >= $past(los_limit)) else $error("loss declared early");
    a_ict_float: assert property (loss_ff[`LGC_LOSS_ICT] |-> !OUT_EN)
        else $error("outputs not floated");
    a_transmitter_on_src: assert property (src_ff[`LGC_SRC_TRANSMITTER_ON] |-> TX_ENABLE == CH_TRANSMITTER_ON)
        else $error("transmit enable source wrong");
    a_term_src: assert property (!src_ff[`LGC_SRC_TERM] |-> TERM_SEL == CH_TERM)
        else $error("termination source wrong");
    a_slicer_code: assert property ((WR && ADDR == `LGC_SLC_ADDR)
        |=> SLICER == lgc_slicer_t'($past(WDATA[3:2]))) else $error("slicer code wrong");
    a_rsv_zero: assert property (fmt_ff[2] == 1'b0 && loss_ff[7:3] == 5'h00
        && src_ff[5:0] == 6'h00 && slc_ff[7:4] == 4'h0 && slc_ff[1:0] == 2'h0)
        else $error("reserved bits set");

    c_los_enter: cover property (!LOSS[0] ##1 LOSS[0]);
    c_mute_out: cover property (LOSS[0] && loss_ff[`LGC_LOSS_MUTE] && RX_STB[0]);
    c_aones_dual: cover property (LOSS[0] && fmt_ff[`LGC_FMT_AONES] && !SINGLE_RAIL && TX_STB[0]);
    c_irq_out: cover property (IRQ);
endmodule // lgc_global_regs
`default_nettype wire

// ===== test/lgc_host_model.sv
// host microprocessor model driving the register strobe port
`timescale 1ns/1ps
`default_nettype none
module lgc_host_model (
    input wire logic clk, // system clock
    input wire logic [7:0] rdata, // read data from the bank
    output logic [7:0] addr, // register address
    output logic [7:0] wdata, // write data
    output logic wr, // write strobe
    output logic rd // read strobe
);
    // bus idles with both strobes low
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end
    // one write: strobe high for exactly one sampling edge
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clk);
        #1;
        wr = 1'b0;
    endtask
    // read: data is taken one edge after the strobe edge, where it is sure to hold
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        addr = a;
        rd = 1'b1;
        @(posedge clk);
        #1;
        rd = 1'b0;
        @(posedge clk);
        #1;
        d = rdata;
    endtask
    // soft reset kept set well past the minimum hold; a single cycle of it already clears every channel
    task automatic soft_reset_hold(input int cyc);
        wr_reg(8'h80, 8'h01);
        repeat (cyc) @(posedge clk);
    endtask
endmodule // lgc_host_model
`default_nettype wire

// ===== test/liu_global_control_regs_tb_top.sv
// self-checking testbench for the global control bank
`timescale 1ns/1ps
`include "lgc_cfg.svh"
`default_nettype none
module liu_global_control_regs_tb_top;
    import lgc_pkg::*;
    logic clk, reset, wr, rd, host_mode, transmitter_on_pin, term_pin, ict_pin_n, global_transmitter_on;
    logic [7:0] addr, wdata, rdata, ch_transmitter_on, ch_term, ch_irq, rx_stb, tx_stb;
    logic [7:0] loss, tx_enable, term_sel, d;
    lgc_rail_t [7:0] rx_line, tx_in, rx_out, tx_line;
    lgc_rail_t a;
    logic [55:0] seg8;
    logic single_rail, rx_fall_edge, tx_rise_edge, soft_reset, irq, out_en;
    lgc_slicer_t slicer;
    int n_mismatch, checked;
    // address, write data, read back, {rail,rxedge,txedge,srst,outen,irq,slicer}
    logic [31:0] rows [19] = '{32'h80808088, 32'h80202048, 32'h80101028, 32'h8002020C,
        32'h80FEFAEC, 32'h80000008, 32'h81FF0700, 32'h81000008, 32'h82FFC008, 32'h82000008,
        32'h83FF0C0B, 32'h83040409, 32'h8308080A, 32'h83000008, 32'h0FFF7F08, 32'h7F555508,
        32'h84FF0008, 32'h10FF0008, 32'h3F2A2A08};
    lgc_global_regs #(.NCH(8)) dut_u (.CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .HOST_MODE(host_mode), .TRANSMITTER_ON_PIN(transmitter_on_pin),
        .TERM_PIN(term_pin), .ICT_PIN_N(ict_pin_n), .GLOBAL_TRANSMITTER_ON(global_transmitter_on),
        .CH_TRANSMITTER_ON(ch_transmitter_on), .CH_TERM(ch_term), .CH_IRQ(ch_irq), .RX_STB(rx_stb),
        .RX_LINE(rx_line), .TX_STB(tx_stb), .TX_IN(tx_in), .RX_OUT(rx_out),
        .TX_LINE(tx_line), .LOSS(loss), .TX_ENABLE(tx_enable), .TERM_SEL(term_sel),
        .SEG8(seg8), .SINGLE_RAIL(single_rail), .RX_FALL_EDGE(rx_fall_edge),
        .TX_RISE_EDGE(tx_rise_edge), .SOFT_RESET(soft_reset), .SLICER(slicer), .IRQ(irq),
        .OUT_EN(out_en));
    lgc_host_model host_u (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd));
    // ****************************************
    // compare, strobe and closing tasks
    // ****************************************
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    // n back-to-back strobes on every channel, then one edge for the registered result
    task automatic run(input bit tx, input int n, input lgc_rail_t r);
        rx_line = {8{r}};
        tx_in = {8{r}};
        repeat (n) begin
            @(posedge clk);
            #1;
            rx_stb = tx ? 8'h00 : 8'hFF;
            tx_stb = tx ? 8'hFF : 8'h00;
        end
        @(posedge clk);
        #1;
        rx_stb = 8'h00;
        tx_stb = 8'h00;
        @(posedge clk);
        #1;
    endtask
    // pins pass a three-flop synchroniser, so wait a little past it
    task automatic pause(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic report_and_stop;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // the run needs about 7000 cycles; this limit leaves ample margin
    initial begin
        #200000;
        n_mismatch++;
        report_and_stop;
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {reset, host_mode, global_transmitter_on, ict_pin_n} = 4'hF;
        {transmitter_on_pin, term_pin} = 2'b00;
        {ch_transmitter_on, ch_term, ch_irq, rx_stb, tx_stb} = 40'h0F33010000;
        rx_line = '0;
        tx_in = '0;
        pause(20);
        reset = 1'b0;
        host_u.rd_reg(8'h80, d);
        chk("fmt reset", 8'h00, d);
        foreach (rows[i]) begin
            host_u.wr_reg(rows[i][31:24], rows[i][23:16]);
            host_u.rd_reg(rows[i][31:24], d);
            chk("rdata", rows[i][15:8], d);
            chk("flags", rows[i][7:0], {single_rail, rx_fall_edge, tx_rise_edge, soft_reset,
                out_en, irq, slicer});
        end
        chk("seg8", {7'h55, 21'h0, 7'h2A, 14'h0, 7'h7F}, seg8);
        // transmitter enable and termination sources
        chk("txen host", 8'hFF, tx_enable);
        host_mode = 1'b0;
        pause(6);
        chk("txen pin lo", 8'h00, tx_enable);
        transmitter_on_pin = 1'b1;
        pause(6);
        chk("txen pin hi", 8'hFF, tx_enable);
        host_u.wr_reg(8'h82, 8'h80);
        chk("txen chan", 8'h0F, tx_enable);
        chk("term chan", 8'h33, term_sel);
        host_u.wr_reg(8'h82, 8'h40);
        term_pin = 1'b1;
        pause(6);
        chk("term pin", 8'hFF, term_sel);
        ict_pin_n = 1'b0;
        pause(6);
        chk("ict pin", 1'b0, out_en);
        ict_pin_n = 1'b1;
        host_u.wr_reg(8'h80, 8'h02);
        ch_irq = 8'h00;
        pause(1);
        chk("irq none", 1'b0, irq);
        ch_irq = 8'h80;
        pause(1);
        chk("irq ch7", 1'b1, irq);
        // loss of signal, polarity and mute
        host_u.wr_reg(8'h80, 8'h00);
        run(0, 31, 2'b00);
        chk("loss 31", 8'h00, loss);
        run(0, 1, 2'b00);
        chk("loss 32", 8'hFF, loss);
        run(0, 1, 2'b10);
        chk("loss clr", 8'h00, loss);
        chk("rx high", {8{2'b10}}, rx_out);
        host_u.wr_reg(8'h81, 8'h02);
        run(0, 4095, 2'b00);
        chk("loss 4095", 8'h00, loss);
        run(0, 1, 2'b00);
        chk("loss 4096", 8'hFF, loss);
        host_u.wr_reg(8'h80, 8'h08);
        run(0, 1, 2'b00);
        chk("rx low", {8{2'b11}}, rx_out);
        run(1, 1, 2'b10);
        chk("tx low", {8{2'b01}}, tx_line);
        host_u.wr_reg(8'h81, 8'h06);
        run(0, 1, 2'b00);
        chk("rx mute", 16'h0000, rx_out);
        // all ones on loss: alternating marks in dual rail starting on pos, pos in single rail
        host_u.wr_reg(8'h80, 8'h40);
        run(1, 1, 2'b00);
        a = tx_line[0];
        chk("aones first", 2'b10, a);
        run(1, 1, 2'b00);
        chk("aones dual", 2'b11, a ^ tx_line[0]);
        host_u.wr_reg(8'h80, 8'hC0);
        run(1, 1, 2'b00);
        chk("aones single", 1'b1, tx_line[0].pos);
        // soft reset held past its minimum clears channels, keeps registers
        host_u.soft_reset_hold(`LGC_SRST_MIN_CYC + 100);
        chk("srst loss", 8'h00, loss);
        chk("srst tx", 16'h0000, tx_line);
        chk("srst flag", 1'b1, soft_reset);
        host_u.rd_reg(8'h81, d);
        chk("srst keep", 8'h06, d);
        // hardware reset in mid-run, most format bits set beforehand so the clear shows
        host_u.wr_reg(8'h80, 8'hFA);
        reset = 1'b1;
        pause(20);
        reset = 1'b0;
        host_u.rd_reg(8'h80, d);
        chk("rst fmt reg", 8'h00, d);
        chk("rst flags", 8'h08, {single_rail, rx_fall_edge, tx_rise_edge, soft_reset, out_en,
            irq, slicer});
        host_u.rd_reg(8'h81, d);
        chk("rst loss reg", 8'h00, d);
        chk("rst seg8", 56'h0, seg8);
        report_and_stop;
    end
endmodule // liu_global_control_regs_tb_top
`default_nettype wire
